/* include/pemb_pkg.sv */
package pemb_pkg;

   // Address control register layout
   localparam int ACR_PAGE_MODE_ENABLE_BIT = 7;
   localparam int ACR_PAGE_SELECT_HIGH_BIT = 6;
   localparam int ACR_PAGE_SELECT_LOW_BIT  = 5;
   localparam logic [7:0] ACR_RESET        = 8'h00;

   // Page select codes
   localparam logic [1:0] SEL_ONE_CLOCK    = 2'h0;
   localparam logic [1:0] SEL_TWO_CLOCK    = 2'h1;
   localparam logic [1:0] SEL_FOUR_CLOCK   = 2'h2;
   localparam logic [1:0] SEL_FAST_CODE    = 2'h3;

   // System clocks per page-hit cycle for each select code
   localparam logic [5:0] HIT_CLOCKS_SEL0  = 6'h01;
   localparam logic [5:0] HIT_CLOCKS_SEL1  = 6'h02;
   localparam logic [5:0] HIT_CLOCKS_SEL2  = 6'h04;
   localparam logic [5:0] HIT_CLOCKS_SEL3  = 6'h02;

   // Classic multiplexed cycle: total clocks and latch phase
   localparam logic [5:0] CLASSIC_CLOCKS   = 6'h04;
   localparam logic [5:0] CLASSIC_LATCH    = 6'h01;

   // Shift giving clocks per stretch machine cycle (1 << 2 = 4)
   localparam int STRETCH_SHIFT            = 2;

   typedef enum logic [1:0] {
      KIND_FETCH,
      KIND_READ,
      KIND_WRITE
   } pemb_kind_e;

   typedef enum logic [1:0] {
      SHAPE_CLASSIC,
      SHAPE_CLASSIC_SWAP,
      SHAPE_PAGE_ONE,
      SHAPE_FAST_CODE
   } pemb_shape_e;

   typedef struct packed {
      pemb_kind_e  kind;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pemb_req_s;

   typedef struct packed {
      logic       ale;
      logic       program_fetch_strobe_n;
      logic       read_strobe_n;
      logic       write_strobe_n;
      logic [7:0] low_port_out;
      logic       low_port_oe;
      logic [7:0] high_port_out;
      logic       high_port_oe;
   } pemb_bus_s;

endpackage

/* rtl/pemb_sequencer.sv */
`timescale 1ns/1ps

// Summary of operation
// - Page mode when enable bit is one
// - Enable zero gives classic multiplexed bus
// - Codes 00/01/10 share ports, differ timing
// - Code 11 fast fetch: 2 hit, 4 miss
// - Code 11 data accesses take four clocks
// - Only timed writes change address control register
// - High port address, low port data
// - Fetch floats low port, opcode latched end
// - Reads float low port, writes drive it
// - Upper byte change is miss, 2/4/8
// - Upper byte same is hit, 1/2/4
// - Hit: low byte on high port, no latch
// - Miss: upper byte, latch strobe, then hit
// - Store page byte, first access misses
// - Code 00 fetch strobe full clock, continuous
// - Code 00 data move and next fetch miss
// - Code 01 fetch strobe one full clock
// - Four-clock mode compares code and data pages
// - Code 11: low port address, high muxed
// - Code 11 data follows classic timing
// - Classic external cycle lasts four clocks
// - Stretch machine cycle adds four clocks
module pemb_sequencer
   import pemb_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Core request side
   input  wire logic       req_valid,
   input  wire pemb_req_s  req,
   input  wire logic [2:0] data_stretch,
   output logic            req_ready,
   output logic            resp_valid,
   output logic [7:0]      resp_data,
   // Address control register write port
   input  wire logic       acr_write,
   input  wire logic       acr_timed,
   input  wire logic [7:0] acr_wdata,
   // Status
   output logic [7:0]      address_control_register,
   output logic            page_mode_enable,
   output logic            page_select_high,
   output logic            page_select_low,
   output logic            last_page_hit,
   output logic            page_valid,
   // External bus pins
   input  wire logic [7:0] low_port_in,
   input  wire logic [7:0] high_port_in,
   output pemb_bus_s       bus
);

   typedef struct packed {
      logic [7:0]  acr;
      logic        busy;
      logic [5:0]  cnt;
      logic [5:0]  total;
      logic [5:0]  prefix;
      logic [5:0]  strobe_at;
      pemb_shape_e shape;
      pemb_req_s   cur;
      logic        page_valid;
      logic [7:0]  page_byte;
      logic        force_miss;
      logic        last_hit;
      logic        req_ready;
      logic        resp_valid;
      logic [7:0]  resp_data;
      pemb_bus_s   bus;
   } pemb_state_s;

   pemb_state_s st;
   pemb_state_s next_st;

   function automatic logic [5:0] hit_clocks(input logic [1:0] sel);
      logic [5:0] n;
      n = HIT_CLOCKS_SEL0;
      unique case (sel)
         SEL_ONE_CLOCK:  n = HIT_CLOCKS_SEL0;
         SEL_TWO_CLOCK:  n = HIT_CLOCKS_SEL1;
         SEL_FOUR_CLOCK: n = HIT_CLOCKS_SEL2;
         SEL_FAST_CODE:  n = HIT_CLOCKS_SEL3;
      endcase
      return n;
   endfunction

   function automatic pemb_bus_s idle_bus();
      pemb_bus_s b;
      b.ale                    = 1'b0;
      b.program_fetch_strobe_n = 1'b1;
      b.read_strobe_n          = 1'b1;
      b.write_strobe_n         = 1'b1;
      b.low_port_out           = 8'h00;
      b.low_port_oe            = 1'b0;
      b.high_port_out          = 8'h00;
      b.high_port_oe           = 1'b0;
      return b;
   endfunction

   // Pin levels for the phase that a state describes
   function automatic pemb_bus_s pins_for(input pemb_state_s s);
      pemb_bus_s b;
      logic      pre;
      logic      stb;
      logic      wr;
      b   = idle_bus();
      pre = s.cnt < s.prefix;
      stb = s.cnt >= s.strobe_at;
      wr  = s.cur.kind == KIND_WRITE;
      if (s.busy) begin
         // Latch strobe only in the address phase; strobes stay off there
         b.ale                    = pre;
         b.program_fetch_strobe_n = !(stb && s.cur.kind == KIND_FETCH);
         b.read_strobe_n          = !(stb && s.cur.kind == KIND_READ);
         b.write_strobe_n         = !(stb && wr);
         unique case (s.shape)
            SHAPE_CLASSIC: begin
               b.low_port_out  = pre ? s.cur.addr[7:0] : s.cur.wdata;
               b.low_port_oe   = pre || wr;
               b.high_port_out = s.cur.addr[15:8];
               b.high_port_oe  = 1'b1;
            end
            SHAPE_CLASSIC_SWAP: begin
               b.low_port_out  = s.cur.addr[7:0];
               b.low_port_oe   = 1'b1;
               b.high_port_out = pre ? s.cur.addr[15:8] : s.cur.wdata;
               b.high_port_oe  = pre || wr;
            end
            SHAPE_PAGE_ONE: begin
               // Upper byte while latching, low byte afterwards
               b.high_port_out = pre ? s.cur.addr[15:8] : s.cur.addr[7:0];
               b.high_port_oe  = 1'b1;
               b.low_port_out  = s.cur.wdata;
               b.low_port_oe   = !pre && wr;
            end
            SHAPE_FAST_CODE: begin
               b.low_port_out  = s.cur.addr[7:0];
               b.low_port_oe   = 1'b1;
               b.high_port_out = s.cur.addr[15:8];
               b.high_port_oe  = pre;
            end
         endcase
      end
      return b;
   endfunction

   always_comb begin
      logic       last;
      logic       pme;
      logic [1:0] sel;
      logic       data;
      logic       hit;
      logic [5:0] h;
      logic [5:0] stretch;
      last    = 1'b0;
      pme     = 1'b0;
      sel     = 2'h0;
      data    = 1'b0;
      hit     = 1'b0;
      h       = 6'h00;
      stretch = 6'h00;
      next_st = st;
      next_st.resp_valid = 1'b0;
      last = st.busy && (st.cnt == st.total - 6'h01);

      // Advance or finish the running cycle
      if (st.busy) begin
         if (last) begin
            next_st.busy = 1'b0;
            if (st.cur.kind != KIND_WRITE) begin
               // Captured as the strobe rises at the end of the cycle
               if (st.shape == SHAPE_CLASSIC_SWAP || st.shape == SHAPE_FAST_CODE) begin
                  next_st.resp_data = high_port_in;
               end else begin
                  next_st.resp_data = low_port_in;
               end
               next_st.resp_valid = 1'b1;
            end else begin
               next_st.resp_valid = 1'b1;
            end
         end else begin
            next_st.cnt = st.cnt + 6'h01;
         end
      end

      // Plan a new cycle; back to back so strobes stay low across hits at select 00
      if ((!st.busy || last) && req_valid && st.req_ready) begin
         pme  = st.acr[ACR_PAGE_MODE_ENABLE_BIT];
         sel  = st.acr[ACR_PAGE_SELECT_HIGH_BIT:ACR_PAGE_SELECT_LOW_BIT];
         data = req.kind != KIND_FETCH;
         // One compare register for code and data addresses
         hit  = st.page_valid && (st.page_byte == req.addr[15:8]) &&
                !(sel == SEL_ONE_CLOCK && (data || st.force_miss));
         h    = hit_clocks(sel);
         stretch = data ? (6'(data_stretch) << STRETCH_SHIFT) : 6'h00;
         next_st.busy = 1'b1;
         next_st.cnt  = 6'h00;
         next_st.cur  = req;
         if (!pme) begin
            // Every classic cycle relatches the upper byte
            next_st.shape      = SHAPE_CLASSIC;
            next_st.prefix     = CLASSIC_LATCH;
            next_st.strobe_at  = CLASSIC_LATCH;
            next_st.total      = CLASSIC_CLOCKS + stretch;
            next_st.page_valid = 1'b0;
            next_st.force_miss = 1'b0;
            next_st.last_hit   = 1'b0;
         end else if (sel == SEL_FAST_CODE && data) begin
            next_st.shape      = SHAPE_CLASSIC_SWAP;
            next_st.prefix     = CLASSIC_LATCH;
            next_st.strobe_at  = CLASSIC_LATCH;
            next_st.total      = CLASSIC_CLOCKS + stretch;
            next_st.page_valid = 1'b1;
            next_st.page_byte  = req.addr[15:8];
            next_st.force_miss = 1'b0;
            next_st.last_hit   = 1'b0;
         end else if (sel == SEL_FAST_CODE) begin
            next_st.shape      = SHAPE_FAST_CODE;
            next_st.prefix     = hit ? 6'h00 : h;
            next_st.strobe_at  = (hit ? 6'h00 : h) + 6'h01;
            next_st.total      = (hit ? 6'h00 : h) + h;
            next_st.page_valid = 1'b1;
            next_st.page_byte  = req.addr[15:8];
            next_st.force_miss = 1'b0;
            next_st.last_hit   = hit;
         end else begin
            // Strobe over the later half of the hit part, whole clock at 00/01
            next_st.shape      = SHAPE_PAGE_ONE;
            next_st.prefix     = hit ? 6'h00 : h;
            next_st.strobe_at  = (hit ? 6'h00 : h) + (h >> 1);
            next_st.total      = (hit ? 6'h00 : h) + h + stretch;
            next_st.page_valid = 1'b1;
            next_st.page_byte  = req.addr[15:8];
            next_st.force_miss = (sel == SEL_ONE_CLOCK) && data;
            next_st.last_hit   = hit;
         end
      end

      // Timed write only; a mode change drops the stored page
      if (acr_write && acr_timed) begin
         if (acr_wdata != st.acr) begin
            next_st.page_valid = 1'b0;
            next_st.force_miss = 1'b0;
         end
         next_st.acr = acr_wdata;
      end

      next_st.req_ready = !next_st.busy || (next_st.cnt == next_st.total - 6'h01);
      next_st.bus       = pins_for(next_st);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st            <= '0;
         st.acr        <= ACR_RESET;
         st.shape      <= SHAPE_CLASSIC;
         st.page_valid <= 1'b0;
         st.req_ready  <= 1'b1;
         st.bus        <= idle_bus();
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign req_ready                = st.req_ready;
   assign resp_valid               = st.resp_valid;
   assign resp_data                = st.resp_data;
   assign address_control_register = st.acr;
   assign page_mode_enable         = st.acr[ACR_PAGE_MODE_ENABLE_BIT];
   assign page_select_high         = st.acr[ACR_PAGE_SELECT_HIGH_BIT];
   assign page_select_low          = st.acr[ACR_PAGE_SELECT_LOW_BIT];
   assign last_page_hit            = st.last_hit;
   assign page_valid               = st.page_valid;
   assign bus                      = st.bus;

endmodule

/* dv/pemb_sequencer_properties.sv */
`timescale 1ns/1ps

module pemb_sequencer_checker
   import pemb_pkg::*;
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Core side
   input wire logic       req_valid,
   input wire pemb_req_s  req,
   input wire logic [2:0] data_stretch,
   input wire logic       req_ready,
   input wire logic       resp_valid,
   // Register and status
   input wire logic       acr_write,
   input wire logic       acr_timed,
   input wire logic [7:0] acr_wdata,
   input wire logic [7:0] address_control_register,
   input wire logic       page_mode_enable,
   input wire logic       page_select_high,
   input wire logic       page_select_low,
   input wire logic       last_page_hit,
   input wire logic       page_valid,
   // Bus pins
   input wire pemb_bus_s  bus
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire logic [1:0] sel      = {page_select_high, page_select_low};
   wire logic       page_one = page_mode_enable && sel != SEL_FAST_CODE;
   wire logic       taken    = req_valid && req_ready;

   AST_RESET_IDLE: assert property (disable iff (1'b0)
      rst |=> !bus.ale && !page_valid)
      else $error("bus not idle after reset");
   AST_ACR_UNTIMED: assert property (
      acr_write && !acr_timed |=> $stable(address_control_register))
      else $error("untimed write changed register");
   AST_ACR_TIMED: assert property (
      acr_write && acr_timed |=> address_control_register == $past(acr_wdata))
      else $error("timed write lost");
   AST_ENABLE_BITS: assert property (
      page_mode_enable == address_control_register[7] && sel == address_control_register[6:5])
      else $error("mode bits mismatch");
   AST_CHANGE_INVALID: assert property (
      acr_write && acr_timed && acr_wdata != address_control_register |=> !page_valid)
      else $error("page kept after mode change");
   AST_ALE_QUIET: assert property (
      bus.ale |-> bus.program_fetch_strobe_n && bus.read_strobe_n && bus.write_strobe_n)
      else $error("strobe during latch phase");
   AST_MISS_PREFIX: assert property (
      bus.ale && page_one |-> !bus.low_port_oe && bus.high_port_oe)
      else $error("miss prefix ports wrong");
   AST_FETCH_FLOAT: assert property (
      !bus.program_fetch_strobe_n && page_one |-> !bus.low_port_oe)
      else $error("low port driven in fetch");
   AST_READ_FLOAT: assert property (
      !bus.read_strobe_n && page_one |-> !bus.low_port_oe)
      else $error("low port driven in read");
   AST_WRITE_DRIVE: assert property (
      !bus.write_strobe_n && page_one |-> bus.low_port_oe)
      else $error("low port floats in write");
   AST_CLASSIC_LEN: assert property (
      taken && !page_mode_enable && data_stretch == 3'h0 |-> ##4 !resp_valid ##1 resp_valid)
      else $error("classic cycle length wrong");
   AST_FAST_DATA: assert property (
      taken && page_mode_enable && sel == SEL_FAST_CODE && req.kind != KIND_FETCH
      && data_stretch == 3'h0 |-> ##4 !resp_valid ##1 resp_valid)
      else $error("fast code data length wrong");
   AST_SEL2_MISS: assert property (
      $rose(bus.ale) && page_mode_enable && sel == SEL_FOUR_CLOCK |-> bus.ale[*4] ##1 !bus.ale)
      else $error("four clock miss prefix wrong");
   AST_SEL1_STROBE: assert property (
      $fell(bus.program_fetch_strobe_n) && page_one && sel == SEL_TWO_CLOCK
      |=> bus.program_fetch_strobe_n)
      else $error("fetch strobe not one clock");

   COV_CLASSIC: cover property (taken && !page_mode_enable);
   COV_BACK_TO_BACK: cover property (taken && !bus.program_fetch_strobe_n);
   COV_ONE_HIT: cover property (last_page_hit && page_mode_enable && sel == SEL_ONE_CLOCK);
   COV_FAST_FETCH: cover property (!bus.program_fetch_strobe_n && sel == SEL_FAST_CODE);
endmodule

bind pemb_sequencer pemb_sequencer_checker u_checker (.clk, .rst, .req_valid, .req, .data_stretch,
   .req_ready, .resp_valid, .acr_write, .acr_timed, .acr_wdata, .address_control_register,
   .page_mode_enable, .page_select_high, .page_select_low, .last_page_hit, .page_valid, .bus);

/* dv/pemb_memory_model.sv */
`timescale 1ns/1ps

module pemb_memory_model
   import pemb_pkg::*;
(
   // Clock and bus
   input  wire logic      clk,
   input  wire logic      page_one,
   input  wire pemb_bus_s bus,
   // Pin levels
   output logic [7:0]     low_port_in,
   output logic [7:0]     high_port_in
);
   logic [7:0] hi_q = 8'h00;
   logic [7:0] lo_q = 8'h00;
   logic [7:0] last = 8'h00;
   logic [7:0] lo;
   logic [7:0] val;
   logic       drive;
   always_comb begin
      lo = page_one ? bus.high_port_out : (bus.low_port_oe ? bus.low_port_out : lo_q);
      drive = !bus.program_fetch_strobe_n || !bus.read_strobe_n;
      // Released lines show the inverse, never a stale copy
      val = drive ? (hi_q ^ lo ^ 8'h5a) : ~last;
      low_port_in = bus.low_port_oe ? bus.low_port_out : val;
      high_port_in = bus.high_port_oe ? bus.high_port_out : val;
   end
   always_ff @(posedge clk) begin
      if (bus.ale) begin
         hi_q <= bus.high_port_out;
         lo_q <= bus.low_port_out;
      end
      if (drive) begin
         last <= val;
      end
   end
endmodule

/* dv/pemb_sequencer_tb_top.sv */
`timescale 1ns/1ps

module pemb_sequencer_tb_top
   import pemb_pkg::*;
;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       req_valid = 1'b0;
   logic       acr_write = 1'b0;
   logic       acr_timed = 1'b0;
   logic       page_one = 1'b0;
   logic [2:0] data_stretch = 3'h0;
   logic [7:0] acr_wdata = 8'h00;
   pemb_req_s  req = '0;
   logic       req_ready, resp_valid, last_page_hit, page_valid;
   logic       page_mode_enable, page_select_high, page_select_low;
   logic [7:0] resp_data, address_control_register, low_port_in, high_port_in;
   pemb_bus_s  bus;
   int         errors = 0;
   int         n_compared = 0;

   always #2 clk = ~clk;

   pemb_sequencer dut (.clk, .rst, .req_valid, .req, .data_stretch, .req_ready, .resp_valid,
      .resp_data, .acr_write, .acr_timed, .acr_wdata, .address_control_register,
      .page_mode_enable, .page_select_high, .page_select_low, .last_page_hit, .page_valid,
      .low_port_in, .high_port_in, .bus);
   pemb_memory_model mem_model (.clk, .page_one, .bus, .low_port_in, .high_port_in);

   function automatic logic [7:0] mem(input logic [15:0] a);
      return a[15:8] ^ a[7:0] ^ 8'h5a;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acr_wr(input logic [7:0] d, input logic t);
      @(posedge clk);
      acr_write <= 1'b1;
      acr_timed <= t;
      acr_wdata <= d;
      @(posedge clk);
      acr_write <= 1'b0;
      if (t) page_one <= d[7] && d[6:5] != SEL_FAST_CODE;
      @(negedge clk);
   endtask

   // Length counted from take edge to response, latch phases alongside
   task automatic xfer(input pemb_kind_e k, input logic [15:0] a, input int len, input int nale);
      int n;
      int na;
      n = 0;
      na = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{k, a, ~a[7:0]};
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req_valid <= 1'b0;
      do begin
         @(negedge clk);
         n++;
         if (bus.ale === 1'b1) na++;
      end while (resp_valid !== 1'b1 && n < 100);
      chk(32'(n - 1), 32'(len));
      chk(32'(na), 32'(nale));
      if (k != KIND_WRITE) chk(32'(resp_data), 32'(mem(a)));
   endtask

   task automatic t_classic();
      chk(32'(address_control_register), 32'(ACR_RESET));
      xfer(KIND_READ, 16'h1234, 4, 1);
      xfer(KIND_WRITE, 16'h1235, 4, 1);
      chk(32'(page_valid), 32'h0);
   endtask

   task automatic t_acr();
      acr_wr(8'ha0, 1'b0);
      chk(32'(address_control_register), 32'h0);
      acr_wr(8'h80, 1'b1);
      chk(32'(page_mode_enable), 32'h1);
   endtask

   task automatic t_page_one();
      int h;
      for (int s = 0; s < 3; s++) begin
         h = 1 << s;
         acr_wr({1'b1, 2'(s), 5'h00}, 1'b1);
         chk(32'(page_valid), 32'h0);
         chk(32'({page_select_high, page_select_low}), 32'(s));
         xfer(KIND_FETCH, 16'h4100, 2 * h, h);
         xfer(KIND_FETCH, 16'h4101, h, 0);
         chk(32'(last_page_hit), 32'h1);
         xfer(KIND_FETCH, 16'h4200, 2 * h, h);
         chk(32'(last_page_hit), 32'h0);
      end
   endtask

   task automatic t_forced_miss();
      acr_wr(8'h80, 1'b1);
      xfer(KIND_FETCH, 16'h4300, 2, 1);
      xfer(KIND_READ, 16'h4300, 2, 1);
      xfer(KIND_FETCH, 16'h4301, 2, 1);
      xfer(KIND_FETCH, 16'h4302, 1, 0);
   endtask

   // Two hits back to back at select 00; the fetch strobe must not lift between them
   task automatic t_back_to_back();
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= '{KIND_FETCH, 16'h4303, 8'h00};
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req       <= '{KIND_FETCH, 16'h4304, 8'h00};
      @(negedge clk);
      chk(32'(bus.program_fetch_strobe_n), 32'h0);
      @(posedge clk);
      req_valid <= 1'b0;
      @(negedge clk);
      chk(32'(bus.program_fetch_strobe_n), 32'h0);
      chk(32'(resp_valid), 32'h1);
      chk(32'(resp_data), 32'(mem(16'h4303)));
      @(negedge clk);
      chk(32'(resp_valid), 32'h1);
      chk(32'(resp_data), 32'(mem(16'h4304)));
   endtask

   task automatic t_four_clock();
      acr_wr(8'hc0, 1'b1);
      xfer(KIND_FETCH, 16'h5500, 8, 4);
      xfer(KIND_READ, 16'h5510, 4, 0);
      @(posedge clk);
      data_stretch <= 3'h1;
      xfer(KIND_WRITE, 16'h5520, 8, 0);
      @(posedge clk);
      data_stretch <= 3'h0;
   endtask

   task automatic t_fast_code();
      acr_wr(8'he0, 1'b1);
      xfer(KIND_FETCH, 16'h6600, 4, 2);
      xfer(KIND_FETCH, 16'h6601, 2, 0);
      xfer(KIND_READ, 16'h6602, 4, 1);
      xfer(KIND_WRITE, 16'h6603, 4, 1);
   endtask

   task automatic finish_test();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #20000;
      errors++;
      finish_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      t_classic();
      t_acr();
      t_page_one();
      t_forced_miss();
      t_back_to_back();
      t_four_clock();
      t_fast_code();
      finish_test();
   end
endmodule
